// ==== rtl/spmap_pkg.sv ====
// package: constants for the sector protection map update block
package spmap_pkg;
  localparam logic [7:0] OP_PREFIX0 = 8'h3D;
  localparam logic [7:0] OP_PREFIX1 = 8'h2A;
  localparam logic [7:0] OP_PREFIX2 = 8'h7F;
  localparam logic [7:0] OP_MAP_ERASE = 8'hCF;
  localparam logic [7:0] OP_MAP_PROGRAM = 8'hFC;
  localparam int MAP_BYTES = 8;
  localparam logic [7:0] MAP_FACTORY = 8'h00;
  localparam logic [7:0] MAP_ERASED = 8'hFF;
  localparam logic [7:0] MAP_PROT = 8'hFF;
  localparam int S0_LOW_HI = 7;
  localparam int S0_LOW_LO = 6;
  localparam int S0_HIGH_HI = 5;
  localparam int S0_HIGH_LO = 4;
  localparam logic [1:0] HALF_PROT = 2'h3;
  localparam int CLK_MHZ = 250;
  localparam int MAP_ERASE_TIME_MAX_US = 10;
  localparam int PROGRAM_TIME_MAX_US = 10;
  localparam int MAP_ERASE_CYC_DEF = MAP_ERASE_TIME_MAX_US * CLK_MHZ;
  localparam int PROGRAM_CYC_DEF = PROGRAM_TIME_MAX_US * CLK_MHZ;
  localparam int CNT_W = 16;
endpackage

// ==== rtl/spi_bytes_if.sv ====
// interface: byte stream from the spi shift stage to the command logic
`timescale 1ns/1ps
interface spi_bytes_if;
  logic frame_start;
  logic byte_valid;
  logic [7:0] byte_data;
  logic frame_end;
  logic on_boundary;
  modport src (output frame_start, byte_valid, byte_data, frame_end, on_boundary);
  modport dst (input frame_start, byte_valid, byte_data, frame_end, on_boundary);
endinterface

// ==== rtl/spi_byte_rx.sv ====
// module: synchronises spi pins and assembles bytes mode 0/3
`timescale 1ns/1ps
module spi_byte_rx (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic cs_b,
  input wire logic sck,
  input wire logic si,
  spi_bytes_if.src bo
);
  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  logic [1:0] cs_s_r, sck_s_r, si_s_r;
  logic cs_d_r, sck_d_r;
  logic [7:0] sh_r;
  logic [2:0] bit_r;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cs_s_r <= 2'h3;
      sck_s_r <= 2'h0;
      si_s_r <= 2'h0;
      cs_d_r <= 1'b1;
      sck_d_r <= 1'b0;
    end else if (ce) begin
      cs_s_r <= {cs_s_r[0], cs_b};
      sck_s_r <= {sck_s_r[0], sck};
      si_s_r <= {si_s_r[0], si};
      cs_d_r <= cs_s_r[1];
      sck_d_r <= sck_s_r[1];
    end
  end
  wire sel = !cs_s_r[1];
  wire rise = sel && sck_s_r[1] && !sck_d_r;
  wire last_bit = bit_r == 3'h7;
  // ----------------------------------------
  // byte assembly, msb first
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sh_r <= 8'h00;
      bit_r <= 3'h0;
    end else if (ce) begin
      if (!sel) begin
        bit_r <= 3'h0;
      end else if (rise) begin
        sh_r <= {sh_r[6:0], si_s_r[1]};
        bit_r <= bit_r + 3'h1;
      end
    end
  end
  assign bo.frame_start = cs_d_r && !cs_s_r[1];
  assign bo.frame_end = !cs_d_r && cs_s_r[1];
  assign bo.on_boundary = bit_r == 3'h0;
  assign bo.byte_valid = rise && last_bit;
  assign bo.byte_data = {sh_r[6:0], si_s_r[1]};
endmodule // spi_byte_rx

// ==== rtl/sector_protect_map_update.sv ====
// module: protection map erase and program command logic
//------------------------------------------------------------
// Operation
// - eight nonvolatile map bytes, byte n governs sector n.
// - sectors 1 to 7: FFh protected, 00h unprotected.
// - sector 0 bits 7:6 low half, 5:4 high half, 11 protects.
// - reset state of every map byte is 00h.
// - map must be erased before reprogramming.
// - 3D 2A 7F CF then chip select high starts map erase.
// - busy shown during erase, bounded by erase time.
// - erase sets all bytes FFh, so all sectors protected.
// - erase accepted whatever global protection state.
// - 3D 2A 7F FC plus eight bytes then chip select starts program; code starts it after any whole number of data bytes from one up.
// - busy shown during program, bounded by program time.
// - ninth data byte wraps to location 0.
// - program accepted whatever global protection state.
// - program overwrites internal buffer contents.
// - write protect low refuses map erase and program.
//------------------------------------------------------------
`timescale 1ns/1ps
module sector_protect_map_update #(
  parameter int MAP_ERASE_CYC = spmap_pkg::MAP_ERASE_CYC_DEF,
  parameter int PROGRAM_CYC = spmap_pkg::PROGRAM_CYC_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic cs_b,
  input wire logic sck,
  input wire logic si,
  input wire logic wp_b,
  input wire logic prot_enabled,
  output logic busy,
  output logic [63:0] map_bytes,
  output logic sector_zero_low_half,
  output logic sector_zero_high_half,
  output logic [7:1] sector_prot,
  output logic [7:0] sector_guard,
  output logic buffer_lost,
  output logic refused
);
  typedef enum {IDLE, OP1, OP2, OP3, ARMED, DATA, JUNK} cmd_type;
  typedef enum {RDY, ERASING, PROGRAMMING} run_type;

  spi_bytes_if bi ();
  spi_byte_rx u_rx (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .cs_b(cs_b),
    .sck(sck),
    .si(si),
    .bo(bi.src)
  );

  logic [1:0] wp_s_r;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wp_s_r <= 2'h3;
    end else if (ce) begin
      wp_s_r <= {wp_s_r[0], wp_b};
    end
  end
  wire wp_low = !wp_s_r[1];

  // ----------------------------------------
  // command decoder
  // ----------------------------------------
  cmd_type cmd_r, cmd_nxt;
  logic is_prog_r, is_prog_nxt;
  logic [2:0] ptr_r;
  logic [7:0] stage_r [spmap_pkg::MAP_BYTES];
  logic [7:0] got_r;
  run_type run_r;
  logic [spmap_pkg::CNT_W-1:0] cnt_r;
  logic [7:0] map_r [spmap_pkg::MAP_BYTES];

  wire bv = bi.byte_valid;
  wire [7:0] bd = bi.byte_data;
  always_comb begin
    cmd_nxt = cmd_r;
    is_prog_nxt = is_prog_r;
    if (bi.frame_start) begin
      cmd_nxt = (run_r == RDY) ? OP1 : JUNK;
    end else if (bv) begin
      case (cmd_r)
        OP1: cmd_nxt = (bd == spmap_pkg::OP_PREFIX0) ? OP2 : JUNK;
        OP2: cmd_nxt = (bd == spmap_pkg::OP_PREFIX1) ? OP3 : JUNK;
        OP3: cmd_nxt = (bd == spmap_pkg::OP_PREFIX2) ? ARMED : JUNK;
        ARMED: begin
          // unknown fourth byte drops the frame
          if (bd == spmap_pkg::OP_MAP_ERASE) begin
            cmd_nxt = DATA;
            is_prog_nxt = 1'b0;
          end else if (bd == spmap_pkg::OP_MAP_PROGRAM) begin
            cmd_nxt = DATA;
            is_prog_nxt = 1'b1;
          end else begin
            cmd_nxt = JUNK;
          end
        end
        DATA: cmd_nxt = DATA;
        default: cmd_nxt = cmd_r;
      endcase
    end
  end

  // erase must carry no data bytes; cs must rise on a byte boundary
  wire end_ok = bi.frame_end && cmd_r == DATA && bi.on_boundary;
  wire go_erase = end_ok && !is_prog_r && got_r == 8'h00;
  wire go_prog = end_ok && is_prog_r && got_r != 8'h00;
  // write protect low refuses both map commands, whatever prot_enabled says
  wire start_erase = go_erase && !wp_low;
  wire start_prog = go_prog && !wp_low;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmd_r <= IDLE;
      is_prog_r <= 1'b0;
      ptr_r <= 3'h0;
      got_r <= 8'h00;
    end else if (ce) begin
      cmd_r <= bi.frame_end ? IDLE : cmd_nxt;
      is_prog_r <= is_prog_nxt;
      // a frame seen while busy must not wipe the bytes the running program still uses
      if (bi.frame_start && run_r == RDY) begin
        ptr_r <= 3'h0;
        got_r <= 8'h00;
      end else if (bv && cmd_r == DATA) begin
        ptr_r <= ptr_r + 3'h1; // wraps past byte 7
        got_r[ptr_r] <= 1'b1;
      end
    end
  end

  // staging bytes model the shared sram buffer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < spmap_pkg::MAP_BYTES; i++) stage_r[i] <= 8'h00;
    end else if (ce && bv && cmd_r == DATA && is_prog_r) begin
      stage_r[ptr_r] <= bd;
    end
  end

  // ----------------------------------------
  // self-timed cycle and map storage
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      run_r <= RDY;
      cnt_r <= '0;
      buffer_lost <= 1'b0;
      refused <= 1'b0;
    end else if (ce) begin
      // any complete map command sent while ready that starts no cycle is reported once
      refused <= bi.frame_end && cmd_r == DATA && !start_erase && !start_prog;
      case (run_r)
        RDY: begin
          if (start_erase) begin
            run_r <= ERASING;
            cnt_r <= spmap_pkg::CNT_W'(MAP_ERASE_CYC - 1);
          end else if (start_prog) begin
            run_r <= PROGRAMMING;
            cnt_r <= spmap_pkg::CNT_W'(PROGRAM_CYC - 1);
            buffer_lost <= 1'b1;
          end
        end
        ERASING, PROGRAMMING: begin
          if (cnt_r == '0) begin
            run_r <= RDY; // bounded by the max time
          end else begin
            cnt_r <= cnt_r - spmap_pkg::CNT_W'(1'h1);
          end
        end
        default: run_r <= RDY;
      endcase
    end
  end

  // program only clears bits, so an unerased map cannot be raised back
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < spmap_pkg::MAP_BYTES; i++) map_r[i] <= spmap_pkg::MAP_FACTORY;
    end else if (ce && cnt_r == '0) begin
      if (run_r == ERASING) begin
        for (int i = 0; i < spmap_pkg::MAP_BYTES; i++) map_r[i] <= spmap_pkg::MAP_ERASED;
      end else if (run_r == PROGRAMMING) begin
        for (int i = 0; i < spmap_pkg::MAP_BYTES; i++) begin
          if (got_r[i]) map_r[i] <= map_r[i] & stage_r[i];
        end
      end
    end
  end

  // ----------------------------------------
  // decoded protection view
  // ----------------------------------------
  function automatic logic half_prot(input logic [1:0] f);
    half_prot = f == spmap_pkg::HALF_PROT;
  endfunction

  assign busy = run_r != RDY;
  always_comb begin
    for (int i = 0; i < spmap_pkg::MAP_BYTES; i++) map_bytes[i*8 +: 8] = map_r[i];
  end
  assign sector_zero_low_half = half_prot(map_r[0][spmap_pkg::S0_LOW_HI:spmap_pkg::S0_LOW_LO]);
  assign sector_zero_high_half =
    half_prot(map_r[0][spmap_pkg::S0_HIGH_HI:spmap_pkg::S0_HIGH_LO]);
  always_comb begin
    for (int i = 1; i < spmap_pkg::MAP_BYTES; i++) sector_prot[i] = map_r[i] == spmap_pkg::MAP_PROT;
  end
  // effective guard on program/erase of each sector
  wire guard_on = prot_enabled || wp_low;
  assign sector_guard = guard_on ?
    {sector_prot, sector_zero_low_half || sector_zero_high_half} : 8'h00;
endmodule // sector_protect_map_update

// ==== tb/spmap_chk.sv ====
// checker: timing and decode properties of the map update block
`timescale 1ns/1ps
module spmap_chk #(
  parameter int MAP_ERASE_CYC = 20,
  parameter int PROGRAM_CYC = 20
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic cs_b,
  input wire logic sck,
  input wire logic si,
  input wire logic wp_b,
  input wire logic prot_enabled,
  input wire logic busy,
  input wire logic [63:0] map_bytes,
  input wire logic sector_zero_low_half,
  input wire logic sector_zero_high_half,
  input wire logic [7:1] sector_prot,
  input wire logic [7:0] sector_guard,
  input wire logic buffer_lost,
  input wire logic refused
);
  // ------
  // helpers
  // ------
  logic [15:0] busy_n_r;
  logic [3:0] wp_lo_r;
  logic [7:1] all_ones;
  always_ff @(posedge clk) begin
    busy_n_r <= (rst_b && busy) ? busy_n_r + 16'h0001 : 16'h0000;
    wp_lo_r <= wp_b ? 4'h0 : wp_lo_r + {3'h0, wp_lo_r != 4'hF};
  end
  always_comb begin
    for (int i = 1; i < 8; i++) begin
      all_ones[i] = map_bytes[8*i+:8] == 8'hFF;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ------
  // properties
  // ------
  a_busy_length: assert property ($fell(busy) |-> busy_n_r inside {MAP_ERASE_CYC, PROGRAM_CYC})
    else $error("busy width wrong");
  a_map_hold_busy: assert property (busy |-> $stable(map_bytes))
    else $error("map moved while busy");
  a_map_idle_hold: assert property (!busy && !$fell(busy) |-> $stable(map_bytes))
    else $error("map moved with no cycle");
  a_program_clears: assert property ($fell(busy) |-> &map_bytes || (map_bytes & ~$past(map_bytes)) == 64'h0)
    else $error("map bits set without erase");
  a_prot_decode: assert property (sector_prot == all_ones)
    else $error("sector decode wrong");
  a_half_decode: assert property (sector_zero_low_half == (map_bytes[7:6] == 2'h3)
    && sector_zero_high_half == (map_bytes[5:4] == 2'h3))
    else $error("half decode wrong");
  a_wp_refuse: assert property ($rose(busy) |-> wp_lo_r < 4'h8)
    else $error("cycle ran with write protect low");
  a_buf_sticky: assert property (buffer_lost |=> buffer_lost)
    else $error("buffer flag dropped");
  a_refused_no_run: assert property (refused |-> !busy ##1 (!busy && !refused) [*8])
    else $error("refused frame started a cycle");
  cover property ($fell(busy) && &map_bytes);
  cover property ($rose(buffer_lost));
  cover property (refused);
endmodule // spmap_chk
bind sector_protect_map_update spmap_chk #(.MAP_ERASE_CYC(MAP_ERASE_CYC),
  .PROGRAM_CYC(PROGRAM_CYC)) u_chk (.*);

// ==== tb/spi_host_model.sv ====
// partner: host spi controller model, mode 0, sck idles low outside frames
`timescale 1ns/1ps
module spi_host_model (
  output logic cs_b,
  output logic sck,
  output logic si
);
  // ------
  // frame driver
  // ------
  initial begin
    cs_b = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // called on a falling clock edge; 40 ns steps keep every change on falling edges
  task automatic frame(input logic [103:0] b, input int nbits);
    cs_b = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si = b[103 - i];
      #40 sck = 1'b1;
      #40 sck = 1'b0;
    end
    #40 cs_b = 1'b1;
    si = ~si;
  endtask
endmodule // spi_host_model

// ==== tb/test_sector_protect_map_update.sv ====
// testbench: map erase, program, wrap and refusal scenarios
`timescale 1ns/1ps
module test_sector_protect_map_update;
  localparam int CYC = 20;
  localparam logic [63:0] PGM_MAP = 64'hFF00FFFF00FF00C7;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wp_b = 1'b1;
  logic prot_enabled = 1'b0;
  logic cs_b, sck, si, busy, sector_zero_low_half, sector_zero_high_half;
  logic buffer_lost, refused;
  logic [63:0] map_bytes;
  logic [7:1] sector_prot;
  logic [7:0] sector_guard;
  int mismatches = 0;
  int n_compared = 0;
  int n_refused = 0;
  always #2 clk = ~clk;
  // refused is a one-cycle pulse, so count it where it stands rather than poll it
  always @(negedge clk) begin
    if (refused === 1'b1) n_refused++;
  end
  spi_host_model host (.cs_b(cs_b), .sck(sck), .si(si));
  sector_protect_map_update #(.MAP_ERASE_CYC(CYC), .PROGRAM_CYC(CYC)) dut (.*, .ce(1'b1));
  // ------
  // shared tasks
  // ------
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op, input logic [71:0] d, input int nbits,
                     input logic runs, input logic refuse);
    int n;
    int r0;
    r0 = n_refused;
    host.frame({8'h3D, 8'h2A, 8'h7F, op, d}, nbits);
    for (n = 0; n < 12 && busy !== 1'b1; n++) @(negedge clk);
    cmp(64'(busy), 64'(runs));
    for (n = 0; n < 200 && busy === 1'b1; n++) @(negedge clk);
    if (runs) cmp(64'(n), 64'(CYC));
    repeat (2) @(negedge clk);
    cmp(64'(n_refused - r0), 64'(refuse));
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_erase();
    cmp(map_bytes, 64'h0);
    prot_enabled = 1'b1;
    cmd(8'hCF, 72'h0, 32, 1'b1, 1'b0);
    cmp(map_bytes, {8{8'hFF}});
    cmp(64'(sector_guard), 64'hFF);
    cmp(64'({sector_prot, sector_zero_low_half, sector_zero_high_half}), 64'h1FF);
    cmp(64'(buffer_lost), 64'h0);
    $display("erase test done");
  endtask
  task automatic t_program();
    cmd(8'hFC, 72'h3000FF00FFFF00FFC7, 104, 1'b1, 1'b0);
    cmp(map_bytes, PGM_MAP);
    cmp(64'({sector_prot, sector_zero_low_half, sector_zero_high_half}), 64'h16A);
    cmp(64'(sector_guard), 64'hB5);
    cmp(64'(buffer_lost), 64'h1);
    $display("program test done");
  endtask
  task automatic t_refuse();
    wp_b = 1'b0;
    prot_enabled = 1'b0;
    repeat (8) @(negedge clk);
    cmp(64'(sector_guard), 64'hB5);
    cmd(8'hCF, 72'h0, 32, 1'b0, 1'b1);
    wp_b = 1'b1;
    repeat (8) @(negedge clk);
    cmp(64'(sector_guard), 64'h0);
    cmd(8'hCF, 72'h0, 20, 1'b0, 1'b0);
    cmd(8'h11, 72'h0, 32, 1'b0, 1'b0);
    cmd(8'hCF, 72'h0, 40, 1'b0, 1'b1);
    cmd(8'hFC, 72'h0, 32, 1'b0, 1'b1);
    cmd(8'hFC, 72'hFF, 36, 1'b0, 1'b1);
    cmd(8'hFC, 72'hFFFFFFFFFFFFFFFF00, 96, 1'b1, 1'b0);
    cmp(map_bytes, PGM_MAP);
    $display("refuse test done");
  endtask
  initial begin
    #300000;
    mismatches++;
    test_done();
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    t_erase();
    t_program();
    t_refuse();
    test_done();
  end
endmodule // test_sector_protect_map_update
